// file: common/pcst_pkg.sv
/*
 * Shared constants and types for the program-counter write and status
 * transfer stage: status word layout, mode codes, decode classes, cycle counts.
 * Assumes a 32-bit core whose instruction word follows the data processing
 * layout (class bits 27:26, immediate bit 25, opcode 24:21, flag bit 20).
 */
package pcst_pkg;

	// ****************************************
	// Status word layout
	// ****************************************
	localparam int WORD_W = 32;
	localparam int FLAG_N_POS = 31;
	localparam int FLAG_V_POS = 28;
	localparam int IRQ_DIS_POS = 7;
	localparam int FIQ_DIS_POS = 6;
	localparam int MODE_W = 5;
	localparam logic [31:0] STATUS_DEFINED_MASK = 32'hF00000DF;
	localparam logic [31:0] STATUS_RESET_VALUE = 32'h000000D3;

	// ****************************************
	// Mode codes and saved word bank
	// ****************************************
	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABORT = 5'h17;
	localparam logic [4:0] MODE_UNDEF = 5'h1B;
	localparam int BANK_DEPTH = 5;
	localparam int BANK_AW = 3;

	// ****************************************
	// Instruction fields and timing
	// ****************************************
	localparam logic [3:0] PC_REG_IDX = 4'hF;
	localparam logic [3:0] SEL_FULL_VIEW = 4'h9;
	localparam logic [3:0] SEL_FLAGS_VIEW = 4'h8;
	localparam logic [31:0] PC_AHEAD_IMM_SHIFT = 32'h00000008;
	localparam logic [31:0] PC_AHEAD_REG_SHIFT = 32'h0000000C;
	localparam logic [1:0] FETCH_NORMAL = 2'h1;
	localparam logic [1:0] FETCH_PC_WRITTEN = 2'h3;
	localparam logic [1:0] FETCH_STATUS_XFER = 2'h1;
	localparam logic [1:0] INTERNAL_REG_SHIFT = 2'h1;

	// Decode classes of an accepted instruction
	typedef enum logic [2:0] {
		CL_NONE = 3'h0,
		CL_DATA = 3'h1,
		CL_TEST = 3'h2,
		CL_LEGACY = 3'h3,
		CL_READ = 3'h4,
		CL_WRITE_FULL = 3'h5,
		CL_WRITE_FLAGS = 3'h6
	} pcst_class_t;

	// Sequencer states, Gray coded along idle-exec-run
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_RUN = 2'h3
	} pcst_state_t;

	// One instruction handed over by the core
	typedef struct packed {
		logic [31:0] word;
		logic [31:0] addr;
		logic [31:0] result;
		logic [3:0] flags;
		logic [31:0] source;
	} pcst_req_t;

	// Register write toward the register file
	typedef struct packed {
		logic we;
		logic [3:0] idx;
		logic [31:0] data;
	} pcst_wb_t;

endpackage

// file: hdl/pcst_bank.sv
/*
 * Banked saved status words, one per privileged mode, with a registered
 * read port and one write port.
 * Assumes writes and reads come from the stage on the same clock.
 */
`timescale 1ns/1ps

module pcst_bank
	import pcst_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = BANK_DEPTH,
	parameter int AW = BANK_AW
)
(
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Synchronous reset, high
	input wire logic wr_en_in, // Write strobe
	input wire logic [AW-1:0] wr_idx_in, // Write slot
	input wire logic [WIDTH-1:0] wr_data_in, // Write data
	input wire logic [AW-1:0] rd_idx_in, // Read slot
	output logic [WIDTH-1:0] rd_data_out // Registered read data
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (DEPTH < 1 || DEPTH > (1 << AW))
	begin : g_depth_bad
		$error("pcst_bank: DEPTH does not fit the index width");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];

	// Storage write
	always_ff @(posedge clk_sys_in)
	begin
		if (wr_en_in && int'(wr_idx_in) < DEPTH)
		begin
			mem_reg[wr_idx_in] <= wr_data_in;
		end
	end

	// Registered read, zero for an absent slot
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			rd_data_out <= '0;
		end
		else if (int'(rd_idx_in) < DEPTH)
		begin
			rd_data_out <= mem_reg[rd_idx_in];
		end
		else
		begin
			rd_data_out <= '0;
		end
	end

endmodule

// file: hdl/pcst_exec.sv
/*
 * Execution stage for data processing writes to the program counter,
 * program counter operand supply, test and compare opcodes, legacy status
 * test, and status word transfers with banked saved status words.
 * Assumes the core has already passed the condition check, computed the ALU
 * result and flags, and presents operand two (register or rotated immediate)
 * as the transfer source. One instruction at a time, ready/valid handshake.
 */
`timescale 1ns/1ps

module pcst_exec
	import pcst_pkg::*;
(
	input wire logic clk_sys_in, // System clock, 200 MHz
	input wire logic rst_in, // Synchronous reset, high
	input wire logic req_valid_in, // Instruction offered
	input wire pcst_req_t req_in, // Instruction and ALU outcome
	output logic ready_out, // Stage can take an instruction
	output pcst_wb_t reg_wb_out, // General register write pulse
	output logic pc_we_out, // Program counter write pulse
	output logic [31:0] pc_value_out, // Program counter new value
	output logic [31:0] pc_operand_out, // Counter value seen as operand
	output logic [31:0] status_word_out, // Current status word
	output logic fetch_cycle_out, // Instruction fetch cycle pulse
	output logic internal_cycle_out, // Internal cycle pulse
	output logic done_out // Last cycle of the instruction
);

	// ****************************************
	// Decode helpers
	// ****************************************

	// Instruction class from its word
	function automatic pcst_class_t decode_class(input logic [31:0] w);
		pcst_class_t c;
		c = CL_NONE;
		if (w[27:26] != 2'b00)
		begin
			c = CL_NONE;
		end
		else if (!w[25] && w[7] && w[4])
		begin
			c = CL_NONE;
		end
		else if (w[24:23] == 2'b10 && !w[20])
		begin
			if (!w[21])
			begin
				c = CL_READ;
			end
			else if (w[19:16] == SEL_FULL_VIEW)
			begin
				c = CL_WRITE_FULL;
			end
			else if (w[19:16] == SEL_FLAGS_VIEW)
			begin
				c = CL_WRITE_FLAGS;
			end
			else
			begin
				c = CL_NONE;
			end
		end
		else if (w[24:23] == 2'b10)
		begin
			c = (w[15:12] == PC_REG_IDX) ? CL_LEGACY : CL_TEST;
		end
		else
		begin
			c = CL_DATA;
		end
		return c;
	endfunction

	// Bank slot for a mode; top bit marks a mode with no saved word
	function automatic logic [BANK_AW:0] bank_slot(input logic [4:0] mode);
		logic [BANK_AW:0] s;
		case (mode)
			MODE_FIQ: s = {1'b0, 3'h0};
			MODE_IRQ: s = {1'b0, 3'h1};
			MODE_SVC: s = {1'b0, 3'h2};
			MODE_ABORT: s = {1'b0, 3'h3};
			MODE_UNDEF: s = {1'b0, 3'h4};
			default: s = {1'b1, 3'h0};
		endcase
		return s;
	endfunction

	// Register specified shift amount
	function automatic logic reg_shift(input logic [31:0] w);
		return !w[25] && w[4];
	endfunction

	// ****************************************
	// State
	// ****************************************
	pcst_state_t state_reg;
	pcst_req_t req_reg;
	pcst_class_t class_reg;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [1:0] fetch_left_reg;
	logic [1:0] fetch_next;
	logic [1:0] int_left_reg;
	logic [1:0] int_next;
	logic [BANK_AW:0] slot;
	logic [31:0] saved_rd;
	logic saved_ok;
	logic privileged;
	logic bank_we;
	logic [31:0] bank_wdata;
	pcst_wb_t wb_next;
	logic pc_we_next;
	logic accept;

	assign accept = (state_reg == ST_IDLE) && ready_out && req_valid_in;
	assign slot = bank_slot(status_reg[MODE_W-1:0]);
	assign saved_ok = !slot[BANK_AW];
	assign privileged = status_reg[MODE_W-1:0] != MODE_USER;

	// ****************************************
	// Saved status word bank
	// ****************************************
	pcst_bank #(
		.WIDTH(WORD_W),
		.DEPTH(BANK_DEPTH),
		.AW(BANK_AW)
	) pcst_bank_i (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.wr_en_in(bank_we),
		.wr_idx_in(slot[BANK_AW-1:0]),
		.wr_data_in(bank_wdata),
		.rd_idx_in(slot[BANK_AW-1:0]),
		.rd_data_out(saved_rd)
	);

	// ****************************************
	// Execution effects
	// ****************************************

	// Status, bank and register effects of the latched instruction
	always_comb
	begin
		status_next = status_reg;
		bank_we = 1'b0;
		bank_wdata = '0;
		wb_next = '0;
		pc_we_next = 1'b0;
		fetch_next = FETCH_NORMAL;
		int_next = reg_shift(req_reg.word) ? INTERNAL_REG_SHIFT : 2'h0;
		if (state_reg == ST_EXEC)
		begin
			case (class_reg)
				CL_DATA:
				begin
					if (req_reg.word[15:12] == PC_REG_IDX)
					begin
						pc_we_next = 1'b1;
						fetch_next = FETCH_PC_WRITTEN;
						if (req_reg.word[20] && saved_ok)
						begin
							status_next = saved_rd & STATUS_DEFINED_MASK;
						end
					end
					else
					begin
						wb_next.we = 1'b1;
						wb_next.idx = req_reg.word[15:12];
						wb_next.data = req_reg.result;
						if (req_reg.word[20])
						begin
							status_next[FLAG_N_POS:FLAG_V_POS] = req_reg.flags;
						end
					end
				end
				CL_TEST:
				begin
					status_next[FLAG_N_POS:FLAG_V_POS] = req_reg.flags;
				end
				CL_LEGACY:
				begin
					if (privileged && saved_ok)
					begin
						status_next = saved_rd & STATUS_DEFINED_MASK;
					end
				end
				CL_READ:
				begin
					fetch_next = FETCH_STATUS_XFER;
					int_next = 2'h0;
					wb_next.we = 1'b1;
					wb_next.idx = req_reg.word[15:12];
					if (req_reg.word[22])
					begin
						wb_next.data = saved_ok ? (saved_rd & STATUS_DEFINED_MASK) : '0;
					end
					else
					begin
						wb_next.data = status_reg & STATUS_DEFINED_MASK;
					end
				end
				CL_WRITE_FULL:
				begin
					fetch_next = FETCH_STATUS_XFER;
					int_next = 2'h0;
					if (req_reg.word[22])
					begin
						bank_we = saved_ok;
						bank_wdata = req_reg.source & STATUS_DEFINED_MASK;
					end
					else if (privileged)
					begin
						status_next = req_reg.source & STATUS_DEFINED_MASK;
					end
					else
					begin
						status_next[FLAG_N_POS:FLAG_V_POS] =
							req_reg.source[FLAG_N_POS:FLAG_V_POS];
					end
				end
				CL_WRITE_FLAGS:
				begin
					fetch_next = FETCH_STATUS_XFER;
					int_next = 2'h0;
					if (req_reg.word[22])
					begin
						bank_we = saved_ok;
						bank_wdata = {req_reg.source[FLAG_N_POS:FLAG_V_POS],
							saved_rd[FLAG_V_POS-1:0] & STATUS_DEFINED_MASK[FLAG_V_POS-1:0]};
					end
					else
					begin
						status_next[FLAG_N_POS:FLAG_V_POS] =
							req_reg.source[FLAG_N_POS:FLAG_V_POS];
					end
				end
				default:
				begin
					status_next = status_reg;
				end
			endcase
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************

	// State and remaining fetch and internal cycles
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			fetch_left_reg <= 2'h0;
			int_left_reg <= 2'h0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					fetch_left_reg <= fetch_next;
					int_left_reg <= int_next;
					state_reg <= ST_RUN;
				end
				ST_RUN:
				begin
					if (fetch_left_reg != 2'h0)
					begin
						fetch_left_reg <= fetch_left_reg - 2'h1;
					end
					else
					begin
						int_left_reg <= int_left_reg - 2'h1;
					end
					if ({1'b0, fetch_left_reg} + {1'b0, int_left_reg} == 3'h1)
					begin
						state_reg <= ST_IDLE;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Cycle strobes and completion
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			fetch_cycle_out <= 1'b0;
			internal_cycle_out <= 1'b0;
			done_out <= 1'b0;
			ready_out <= 1'b0;
		end
		else
		begin
			fetch_cycle_out <= (state_reg == ST_RUN) && (fetch_left_reg != 2'h0);
			internal_cycle_out <= (state_reg == ST_RUN) && (fetch_left_reg == 2'h0);
			done_out <= (state_reg == ST_RUN) &&
				({1'b0, fetch_left_reg} + {1'b0, int_left_reg} == 3'h1);
			ready_out <= (state_reg == ST_IDLE && !req_valid_in) ||
				(state_reg == ST_RUN &&
				{1'b0, fetch_left_reg} + {1'b0, int_left_reg} == 3'h1);
		end
	end

	// ****************************************
	// Instruction capture
	// ****************************************

	// Latch the offered instruction and its counter operand
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			req_reg <= '0;
			class_reg <= CL_NONE;
			pc_operand_out <= '0;
		end
		else if (accept)
		begin
			req_reg <= req_in;
			class_reg <= decode_class(req_in.word);
			if (reg_shift(req_in.word))
			begin
				pc_operand_out <= req_in.addr + PC_AHEAD_REG_SHIFT;
			end
			else
			begin
				pc_operand_out <= req_in.addr + PC_AHEAD_IMM_SHIFT;
			end
		end
	end

	// ****************************************
	// Status word and write-back
	// ****************************************

	// Current status word, reserved bits held at zero
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			status_reg <= STATUS_RESET_VALUE;
			status_word_out <= STATUS_RESET_VALUE;
		end
		else
		begin
			status_reg <= status_next & STATUS_DEFINED_MASK;
			status_word_out <= status_next & STATUS_DEFINED_MASK;
		end
	end

	// Register and counter write pulses
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			reg_wb_out <= '0;
			pc_we_out <= 1'b0;
			pc_value_out <= '0;
		end
		else
		begin
			reg_wb_out <= wb_next;
			pc_we_out <= pc_we_next;
			if (pc_we_next)
			begin
				pc_value_out <= req_reg.result;
			end
		end
	end

endmodule

// file: verif/pcst_monitor.sv
/*
 * Port checker for pcst_exec: counter writes, flag loads, status transfers.
 * Assumes it is bound to pcst_exec, with clk_sys_in as the only clock.
 */
`timescale 1ns/1ps

module pcst_monitor
	import pcst_pkg::*;
(
	input wire logic clk_sys_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic req_valid_in, // Offer
	input wire pcst_req_t req_in, // Instruction
	input wire logic ready_out, // Ready
	input wire pcst_wb_t reg_wb_out, // Register write
	input wire logic pc_we_out, // Counter write
	input wire logic [31:0] pc_value_out, // Counter value
	input wire logic [31:0] pc_operand_out, // Counter operand
	input wire logic [31:0] status_word_out, // Status word
	input wire logic fetch_cycle_out, // Fetch pulse
	input wire logic internal_cycle_out, // Internal pulse
	input wire logic done_out // Last cycle
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// **********
	// Decode of the offered word
	// **********
	logic tk, dp, rs, rd15, tst, xw, xs;
	logic pw, rsq;
	logic [2:0] fc, ic;
	logic [31:0] w;
	assign w = req_in.word;
	assign tk = req_valid_in && ready_out;
	assign dp = w[27:26] == 2'h0 && !(!w[25] && w[7] && w[4]);
	assign rs = !w[25] && w[4];
	assign rd15 = w[15:12] == PC_REG_IDX;
	assign tst = w[24:23] == 2'h2;
	assign xw = dp && tst && !w[20] && w[21];
	assign xs = dp && tst && !w[20] && (!w[21] || w[19:16] == SEL_FULL_VIEW
		|| w[19:16] == SEL_FLAGS_VIEW);

	// Pulse counts since the last take
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in || tk)
		begin
			fc <= 3'h0;
			ic <= 3'h0;
			pw <= 1'b0;
			rsq <= tk && dp && rs;
		end
		else
		begin
			fc <= fc + {2'h0, fetch_cycle_out};
			ic <= ic + {2'h0, internal_cycle_out};
			pw <= pw | pc_we_out;
		end
	end

	// Status transfer: busy, quiet, then one fetch that ends it
	sequence s_xfer_walk;
		!ready_out ##1 !fetch_cycle_out ##1 (fetch_cycle_out && done_out && ready_out);
	endsequence

	a_reserved_zero: assert property ((status_word_out & ~STATUS_DEFINED_MASK) == 32'h0)
		else $error("reserved status bits set");
	a_fetch_count: assert property (done_out |-> fc + {2'h0, fetch_cycle_out} == (pw ? 3'h3 : 3'h1))
		else $error("wrong fetch count");
	a_internal_count: assert property (done_out |-> ic + {2'h0, internal_cycle_out} == {2'h0, rsq})
		else $error("wrong internal count");
	a_operand_ahead: assert property (tk && dp |=> pc_operand_out == $past(req_in.addr)
		+ ($past(rs) ? PC_AHEAD_REG_SHIFT : PC_AHEAD_IMM_SHIFT))
		else $error("counter operand offset wrong");
	a_pc_write: assert property (tk && dp && rd15 && !tst |-> ##2 pc_we_out
		&& pc_value_out == $past(req_in.result, 2))
		else $error("counter not written");
	a_status_kept: assert property (tk && dp && rd15 && !tst && !w[20] |-> ##2
		status_word_out == $past(status_word_out, 2))
		else $error("status changed on plain counter write");
	a_flags_load: assert property (tk && dp && w[20] && !rd15 |-> ##2
		status_word_out == {$past(req_in.flags, 2), $past(status_word_out[27:0], 2)})
		else $error("flags not loaded");
	a_flags_write: assert property (tk && xw && !w[22] && w[19:16] == SEL_FLAGS_VIEW |-> ##2
		status_word_out == {$past(req_in.source[31:28], 2), $past(status_word_out[27:0], 2)})
		else $error("flags-only write wrong");
	a_user_guard: assert property (tk && xw && !w[22] && w[19:16] == SEL_FULL_VIEW
		&& status_word_out[4:0] == MODE_USER |-> ##2
		status_word_out == {$past(req_in.source[31:28], 2), $past(status_word_out[27:0], 2)})
		else $error("user mode control bits changed");
	a_read_word: assert property (tk && xs && !w[21] && !w[22] |-> ##2 reg_wb_out.we
		&& reg_wb_out.idx == $past(w[15:12], 2) && reg_wb_out.data == status_word_out)
		else $error("status read wrong");
	a_xfer_walk: assert property (tk && xs |=> s_xfer_walk)
		else $error("status transfer timing wrong");
endmodule

bind pcst_exec pcst_monitor pcst_monitor_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.req_valid_in(req_valid_in), .req_in(req_in), .ready_out(ready_out),
	.reg_wb_out(reg_wb_out), .pc_we_out(pc_we_out), .pc_value_out(pc_value_out),
	.pc_operand_out(pc_operand_out), .status_word_out(status_word_out),
	.fetch_cycle_out(fetch_cycle_out), .internal_cycle_out(internal_cycle_out),
	.done_out(done_out));

// file: verif/pcst_exec_tb_top.sv
/*
 * Self-checking bench for pcst_exec: status transfers, counter writes, timing.
 * Assumes the port checker is bound from its own file.
 */
`timescale 1ns/1ps

module pcst_exec_tb_top import pcst_pkg::*;;
	logic clk_sys_in, rst_in, req_valid_in, ready_out, pc_we_out;
	logic fetch_cycle_out, internal_cycle_out, done_out;
	logic [31:0] pc_value_out, pc_operand_out, status_word_out, wb_data, pc_seen;
	pcst_req_t req_in;
	pcst_wb_t reg_wb_out;
	int miscompares, checks, nf, ni, nw;

	pcst_exec pcst_exec_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .ready_out(ready_out),
		.reg_wb_out(reg_wb_out), .pc_we_out(pc_we_out), .pc_value_out(pc_value_out),
		.pc_operand_out(pc_operand_out), .status_word_out(status_word_out),
		.fetch_cycle_out(fetch_cycle_out), .internal_cycle_out(internal_cycle_out),
		.done_out(done_out));

	// 200 MHz clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	// **********
	// Shared tasks
	// **********
	task automatic print_verdict;
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Offer one instruction, then count pulses until done
	task automatic go(input logic [31:0] w, a, r, s, input logic [3:0] f);
		int n;
		n = 0;
		while (ready_out !== 1'b1 && n < 50)
		begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		if (n >= 50)
		begin
			miscompares++;
		end
		@(posedge clk_sys_in);
		req_valid_in <= 1'b1;
		req_in <= '{word: w, addr: a, result: r, flags: f, source: s};
		@(posedge clk_sys_in);
		req_valid_in <= 1'b0;
		nf = 0;
		ni = 0;
		nw = 0;
		pc_seen = 32'hFFFFFFFF;
		do
		begin
			@(posedge clk_sys_in);
			#1;
			nf += int'(fetch_cycle_out === 1'b1);
			ni += int'(internal_cycle_out === 1'b1);
			if (reg_wb_out.we === 1'b1)
			begin
				nw++;
				wb_data = reg_wb_out.data;
			end
			if (pc_we_out === 1'b1)
				pc_seen = pc_value_out;
			n++;
		end
		while (done_out !== 1'b1 && n < 100);
		if (done_out !== 1'b1)
		begin
			miscompares++;
		end
	endtask

	// Status word and pulse counts after an instruction
	task automatic ex(input logic [31:0] sw, input int f, input int i);
		chk(status_word_out, sw);
		chk(nf, f);
		chk(ni, i);
	endtask

	// **********
	// Scenarios
	// **********
	task automatic t_flags;
		go(32'hE328F000, 32'h100, 32'h0, 32'hA0000000, 4'h0);
		ex(32'hA00000D3, 1, 0);
	endtask

	task automatic t_saved;
		go(32'hE169F001, 32'h100, 32'h0, 32'h6FFFFFD1, 4'h0);
		ex(32'hA00000D3, 1, 0);
		go(32'hE168F001, 32'h100, 32'h0, 32'hC0000000, 4'h0);
		go(32'hE14F3000, 32'h100, 32'h0, 32'h0, 4'h0);
		chk(wb_data, 32'hC00000D1);
		go(32'hE10F3000, 32'h100, 32'h0, 32'h0, 4'h0);
		chk(wb_data, 32'hA00000D3);
		chk(nw, 1);
	endtask

	// Other mode's saved word must not leak into supervisor's
	task automatic t_bank;
		go(32'hE129F001, 32'h100, 32'h0, 32'h000000D2, 4'h0);
		ex(32'h000000D2, 1, 0);
		go(32'hE169F001, 32'h100, 32'h0, 32'h90000012, 4'h0);
		go(32'hE129F001, 32'h100, 32'h0, 32'h000000D3, 4'h0);
		go(32'hE14F3000, 32'h100, 32'h0, 32'h0, 4'h0);
		chk(wb_data, 32'hC00000D1);
		go(32'hE129F001, 32'h100, 32'h0, 32'h000000DB, 4'h0);
		go(32'hE169F001, 32'h100, 32'h0, 32'h500000DB, 4'h0);
		go(32'hE14F3000, 32'h100, 32'h0, 32'h0, 4'h0);
		chk(wb_data, 32'h500000DB);
		go(32'hE129F001, 32'h100, 32'h0, 32'h000000D3, 4'h0);
		ex(32'h000000D3, 1, 0);
	endtask

	task automatic t_dp;
		go(32'hE2912001, 32'h100, 32'h55, 32'h0, 4'h9);
		ex(32'h900000D3, 1, 0);
		chk(pc_operand_out, 32'h108);
		go(32'hE0912315, 32'h200, 32'h55, 32'h0, 4'h6);
		ex(32'h600000D3, 1, 1);
		chk(pc_operand_out, 32'h20C);
		go(32'hE3510001, 32'h100, 32'h55, 32'h0, 4'h2);
		ex(32'h200000D3, 1, 0);
		chk(nw, 0);
	endtask

	task automatic t_pc;
		go(32'hE3A0F000, 32'h100, 32'h1000, 32'h0, 4'hF);
		ex(32'h200000D3, 3, 0);
		chk(pc_seen, 32'h1000);
		go(32'hE1A0F315, 32'h300, 32'h2000, 32'h0, 4'hF);
		ex(32'h200000D3, 3, 1);
		go(32'hE3B0F000, 32'h100, 32'h3000, 32'h0, 4'hF);
		ex(32'hC00000D1, 3, 0);
		chk(pc_seen, 32'h3000);
	endtask

	// Legacy status test restores the saved word only outside User mode; User mode status writes change flags only
	task automatic t_user;
		go(32'hE129F001, 32'h100, 32'h0, 32'h000000D3, 4'h0);
		go(32'hE330F000, 32'h100, 32'h0, 32'h0, 4'h0);
		ex(32'hC00000D1, 1, 0);
		go(32'hE129F001, 32'h100, 32'h0, 32'h00000010, 4'h0);
		go(32'hE330F000, 32'h100, 32'h0, 32'h0, 4'h0);
		ex(32'h00000010, 1, 0);
		go(32'hE129F001, 32'h100, 32'h0, 32'hF00000D3, 4'h0);
		ex(32'hF0000010, 1, 0);
	endtask

	// Reset during a counter write, outputs at release, then one clean read
	task automatic t_reset;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b1;
		req_in <= '{word: 32'hE3A0F000, addr: 32'h100, result: 32'h4000,
			flags: 4'h0, source: 32'h0};
		@(posedge clk_sys_in);
		req_valid_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		chk(ready_out, 32'h0);
		@(posedge clk_sys_in);
		#1;
		chk(ready_out, 32'h1);
		chk(status_word_out, 32'h000000D3);
		chk(pc_value_out, 32'h0);
		go(32'hE10F3000, 32'h100, 32'h0, 32'h0, 4'h0);
		ex(32'h000000D3, 1, 0);
		chk(wb_data, 32'h000000D3);
	endtask

	// Reset, then every scenario in turn
	initial
	begin
		miscompares = 0;
		checks = 0;
		rst_in = 1'b1;
		req_valid_in = 1'b0;
		req_in = '0;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk(status_word_out, 32'h000000D3);
		t_flags();
		t_saved();
		t_bank();
		t_dp();
		t_pc();
		t_user();
		t_reset();
		print_verdict();
	end
endmodule
